// >>> rtl/lcem_cfg.svh
`ifndef LCEM_CFG_SVH
`define LCEM_CFG_SVH

// Register byte addresses
`define LCEM_ADDR_CTRL  8'h00
`define LCEM_ADDR_BUSY  8'h04
`define LCEM_ADDR_SUPV  8'h08
`define LCEM_ADDR_STAT  8'h0c

// Control register bit positions
`define LCEM_CTRL_PCR   0
`define LCEM_CTRL_ACC   1
`define LCEM_CTRL_EMG   2
`define LCEM_CTRL_W     3
`define LCEM_CTRL_RST   3'h0

// Timer intervals in milliseconds, counted on the 1 ms tick
`define LCEM_BUSY_RST   16'h0064
`define LCEM_SUPV_RST   16'h0bb8

// Clock period and tick period in nanoseconds
`define LCEM_CLK_NS     25
`define LCEM_TICK_NS    1000000

// Congestion hysteresis in ticks
`define LCEM_CONG_HOLD  3

// Error monitor figures
`define LCEM_IN_SERVICE_ERROR_MONITOR_T    64
`define LCEM_IN_SERVICE_ERROR_MONITOR_D    256
`define LCEM_OCTET_N    16
`define LCEM_TIN        4
`define LCEM_TIE        1
`define LCEM_ABORT_M    5

// Length indicator range of a link status unit
`define LCEM_LI_MIN     6'h01
`define LCEM_LI_MAX     6'h02

`endif

// >>> rtl/lcem_pkg.sv
package lcem_pkg;

  typedef enum logic [2:0] {
    LCEM_ST_O  = 3'h0,
    LCEM_ST_N  = 3'h1,
    LCEM_ST_E  = 3'h2,
    LCEM_ST_OS = 3'h3,
    LCEM_ST_PO = 3'h4,
    LCEM_ST_B  = 3'h5
  } lcem_status_e;

  typedef enum logic [1:0] {
    LCEM_PR_IDLE  = 2'h0,
    LCEM_PR_RUN   = 2'h1,
    LCEM_PR_ABORT = 2'h3
  } lcem_prove_e;

  typedef struct packed {
    logic [4:0]   spare;
    lcem_status_e code;
  } lcem_lsu_s;

  typedef struct packed {
    logic emergency;
    logic accept_cong;
    logic preventive_cyclic_retransmission;
  } lcem_cfg_s;

endpackage : lcem_pkg

// >>> rtl/lcem_top.sv
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "lcem_cfg.svh"

module lcem_top
  import lcem_pkg::*;
#(
  parameter int TICK_CYCLES = `LCEM_TICK_NS / `LCEM_CLK_NS,
  parameter int CONG_HOLD   = `LCEM_CONG_HOLD,
  parameter int IN_SERVICE_ERROR_MONITOR_T     = `LCEM_IN_SERVICE_ERROR_MONITOR_T,
  parameter int IN_SERVICE_ERROR_MONITOR_D     = `LCEM_IN_SERVICE_ERROR_MONITOR_D,
  parameter int OCTET_N     = `LCEM_OCTET_N,
  parameter int NORMAL_PROVING_THRESHOLD         = `LCEM_TIN,
  parameter int EMERGENCY_PROVING_THRESHOLD         = `LCEM_TIE,
  parameter int ABORT_M     = `LCEM_ABORT_M
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [7:0]   addr_i,
  input  wire logic [31:0]  wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic      [31:0]  rdata_o,
  input  wire logic         cong_level_i,
  input  wire logic         tx_unit_sent_i,
  input  wire logic [6:0]   tx_bsn_i,
  input  wire logic         tx_bib_i,
  output logic      [6:0]   tx_bsn_o,
  output logic              tx_bib_o,
  output logic              ack_enable_o,
  output logic              accept_msu_o,
  output logic              bsn_process_o,
  output logic              congested_o,
  output logic              busy_lsu_req_o,
  input  wire lcem_status_e tx_status_i,
  output lcem_lsu_s         tx_status_octet_o,
  input  wire logic         rx_unit_i,
  input  wire logic [5:0]   rx_li_i,
  input  wire logic [7:0]   rx_octet_i,
  output lcem_lsu_s         rx_lsu_o,
  output logic              rx_lsu_valid_o,
  input  wire logic         rx_pos_ack_i,
  input  wire logic         rx_neg_ack_i,
  output logic              ack_delay_restart_o,
  output logic              link_fail_o,
  input  wire logic         su_err_i,
  input  wire logic         su_ok_i,
  input  wire logic         octet_i,
  input  wire logic         octet_mode_i,
  input  wire logic         in_service_i,
  output logic              err_rate_high_o,
  input  wire logic         prove_enter_i,
  input  wire logic         prove_expire_i,
  output logic              prove_abort_o,
  output logic              prove_done_o,
  output logic              prove_oos_o
);

  localparam int TW = $clog2(TICK_CYCLES);
  localparam int SW = $clog2(IN_SERVICE_ERROR_MONITOR_T + 1);
  localparam int DW = $clog2(IN_SERVICE_ERROR_MONITOR_D);
  localparam int NW = $clog2(OCTET_N);
  localparam int AW = $clog2(NORMAL_PROVING_THRESHOLD + 1);
  localparam int MW = $clog2(ABORT_M);
  localparam int HW = $clog2(CONG_HOLD + 1);

  lcem_cfg_s   cfg_q;
  logic [15:0] busy_per_q;
  logic [15:0] supv_per_q;
  logic [TW-1:0] tick_cnt_q;
  logic        tick;

  // Register port
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_q      <= `LCEM_CTRL_RST;
      busy_per_q <= `LCEM_BUSY_RST;
      supv_per_q <= `LCEM_SUPV_RST;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        `LCEM_ADDR_CTRL: cfg_q      <= wdata_i[`LCEM_CTRL_W-1:0];
        `LCEM_ADDR_BUSY: busy_per_q <= wdata_i[15:0];
        `LCEM_ADDR_SUPV: supv_per_q <= wdata_i[15:0];
        default:         cfg_q      <= cfg_q;
      endcase
    end
  end

  // Millisecond tick shared by all timers
  assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tick_cnt_q <= '0;
    else if (tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + TW'(1);
  end

  // Congestion with hysteresis: the input must differ through CONG_HOLD
  // ticks in a row before the state flips, so buffer jitter cannot toggle it.
  logic          cong_q;
  logic [HW-1:0] hold_q;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cong_q <= 1'b0;
      hold_q <= '0;
    end
    else if (cong_level_i == cong_q)
      hold_q <= '0;
    else if (tick)
    begin
      if (hold_q == HW'(CONG_HOLD - 1))
      begin
        cong_q <= cong_level_i;
        hold_q <= '0;
      end
      else
        hold_q <= hold_q + HW'(1);
    end
  end

  assign congested_o   = cong_q;
  assign ack_enable_o  = !cong_q;
  assign accept_msu_o  = !cong_q || cfg_q.accept_cong;
  assign bsn_process_o = 1'b1;

  // Backward fields frozen at the last unit sent before congestion
  logic [6:0] held_bsn_q;
  logic       held_bib_q;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      held_bsn_q <= '0;
      held_bib_q <= 1'b0;
    end
    else if (tx_unit_sent_i && !cong_q)
    begin
      held_bsn_q <= tx_bsn_o;
      held_bib_q <= tx_bib_o;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_bsn_o <= '0;
      tx_bib_o <= 1'b0;
    end
    else
    begin
      tx_bsn_o <= cong_q ? held_bsn_q : tx_bsn_i;
      tx_bib_o <= cong_q ? held_bib_q : tx_bib_i;
    end
  end

  // Busy repeat: one unit at onset, then one per interval
  logic [15:0] busy_cnt_q;
  logic        cong_d1_q;
  logic        busy_fire;

  assign busy_fire = cong_q && (!cong_d1_q ||
                     (tick && busy_cnt_q >= busy_per_q - 16'h0001));

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cong_d1_q  <= 1'b0;
      busy_cnt_q <= '0;
      busy_lsu_req_o <= 1'b0;
    end
    else
    begin
      cong_d1_q      <= cong_q;
      busy_lsu_req_o <= busy_fire;
      if (!cong_q || busy_fire)
        busy_cnt_q <= '0;
      else if (tick)
        busy_cnt_q <= busy_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tx_status_octet_o <= '0;
    else
    begin
      tx_status_octet_o.spare <= '0;
      tx_status_octet_o.code  <= busy_fire ? LCEM_ST_B : tx_status_i;
    end
  end

  // Received status unit decode; any second octet is ignored
  logic      rx_is_lsu;
  lcem_lsu_s rx_dec;

  assign rx_is_lsu = rx_unit_i && rx_li_i >= `LCEM_LI_MIN &&
                     rx_li_i <= `LCEM_LI_MAX;
  assign rx_dec    = rx_octet_i;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_lsu_o       <= '0;
      rx_lsu_valid_o <= 1'b0;
    end
    else
    begin
      rx_lsu_valid_o <= rx_is_lsu;
      if (rx_is_lsu)
        rx_lsu_o <= rx_dec;
    end
  end

  // Far-end busy handling and supervision
  logic        rx_busy;
  logic        supv_run_q;
  logic [15:0] supv_cnt_q;
  logic        supv_stop;

  assign rx_busy   = rx_lsu_valid_o && rx_lsu_o.code == LCEM_ST_B;
  assign supv_stop = rx_pos_ack_i || (rx_neg_ack_i && !cfg_q.preventive_cyclic_retransmission);

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      supv_run_q <= 1'b0;
      supv_cnt_q <= '0;
      link_fail_o <= 1'b0;
      ack_delay_restart_o <= 1'b0;
    end
    else
    begin
      ack_delay_restart_o <= rx_busy;
      link_fail_o <= 1'b0;
      if (supv_stop)
        supv_run_q <= 1'b0;
      else if (rx_busy && !supv_run_q)
      begin
        supv_run_q <= 1'b1;
        supv_cnt_q <= '0;
      end
      else if (supv_run_q && tick)
      begin
        if (supv_cnt_q >= supv_per_q - 16'h0001)
        begin
          supv_run_q  <= 1'b0;
          link_fail_o <= 1'b1;
        end
        else
          supv_cnt_q <= supv_cnt_q + 16'h0001;
      end
    end
  end

  // Error increments shared by both monitors
  logic [NW-1:0] oct_cnt_q;
  logic          oct_inc;
  logic          err_inc;

  assign oct_inc = octet_mode_i && octet_i &&
                   oct_cnt_q == NW'(OCTET_N - 1);
  assign err_inc = octet_mode_i ? oct_inc : su_err_i;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      oct_cnt_q <= '0;
    else if (!octet_mode_i)
      oct_cnt_q <= '0;
    else if (octet_i)
      oct_cnt_q <= oct_cnt_q + NW'(1);
  end

  // In-service monitor
  logic [SW-1:0] se_cnt_q;
  logic [DW-1:0] d_cnt_q;
  logic          insv_d1_q;
  logic          dec_ev;

  assign dec_ev = (su_ok_i || su_err_i) && d_cnt_q == DW'(IN_SERVICE_ERROR_MONITOR_D - 1);

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      insv_d1_q <= 1'b0;
      se_cnt_q  <= '0;
      d_cnt_q   <= '0;
    end
    else
    begin
      insv_d1_q <= in_service_i;
      if (in_service_i && !insv_d1_q)
      begin
        se_cnt_q <= '0;
        d_cnt_q  <= '0;
      end
      else if (in_service_i)
      begin
        if (su_ok_i || su_err_i)
          d_cnt_q <= d_cnt_q + DW'(1);
        if (err_inc && !dec_ev && se_cnt_q != SW'(IN_SERVICE_ERROR_MONITOR_T))
          se_cnt_q <= se_cnt_q + SW'(1);
        else if (dec_ev && !err_inc && se_cnt_q != '0)
          se_cnt_q <= se_cnt_q - SW'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      err_rate_high_o <= 1'b0;
    else
      err_rate_high_o <= in_service_i &&
                         se_cnt_q == SW'(IN_SERVICE_ERROR_MONITOR_T);
  end

  // Alignment monitor and proving supervision
  lcem_prove_e   pr_q;
  logic [AW-1:0] ae_cnt_q;
  logic [MW-1:0] ab_cnt_q;
  logic          bad_q;
  logic [AW-1:0] thr;
  logic          hit;
  logic          rx_bad;

  assign thr    = cfg_q.emergency ? AW'(EMERGENCY_PROVING_THRESHOLD) : AW'(NORMAL_PROVING_THRESHOLD);
  assign hit    = err_inc && (ae_cnt_q + AW'(1)) >= thr;
  assign rx_bad = rx_lsu_valid_o && (rx_lsu_o.code == LCEM_ST_O ||
                  rx_lsu_o.code == LCEM_ST_OS);

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pr_q          <= LCEM_PR_IDLE;
      ae_cnt_q      <= '0;
      ab_cnt_q      <= '0;
      bad_q         <= 1'b0;
      prove_abort_o <= 1'b0;
      prove_done_o  <= 1'b0;
      prove_oos_o   <= 1'b0;
    end
    else
    begin
      prove_abort_o <= 1'b0;
      prove_done_o  <= 1'b0;
      prove_oos_o   <= 1'b0;
      if (prove_enter_i)
      begin
        pr_q     <= LCEM_PR_RUN;
        ae_cnt_q <= '0;
        ab_cnt_q <= '0;
        bad_q    <= 1'b0;
      end
      else
      begin
        unique case (pr_q)
          LCEM_PR_IDLE: pr_q <= LCEM_PR_IDLE;
          LCEM_PR_RUN:
          begin
            if (hit)
            begin
              prove_abort_o <= 1'b1;
              if (ab_cnt_q == MW'(ABORT_M - 1))
              begin
                prove_oos_o <= 1'b1;
                pr_q        <= LCEM_PR_IDLE;
              end
              else
              begin
                ab_cnt_q <= ab_cnt_q + MW'(1);
                pr_q     <= LCEM_PR_ABORT;
              end
            end
            else if (prove_expire_i)
            begin
              // A tainted period simply runs again
              if (!bad_q && !rx_bad)
              begin
                prove_done_o <= 1'b1;
                pr_q         <= LCEM_PR_IDLE;
              end
              ae_cnt_q <= '0;
              bad_q    <= 1'b0;
            end
            else
            begin
              if (err_inc)
                ae_cnt_q <= ae_cnt_q + AW'(1);
              if (rx_bad)
                bad_q <= 1'b1;
            end
          end
          LCEM_PR_ABORT:
          begin
            if (su_ok_i || prove_expire_i)
            begin
              pr_q     <= LCEM_PR_RUN;
              ae_cnt_q <= '0;
              bad_q    <= 1'b0;
            end
          end
          default: pr_q <= LCEM_PR_IDLE;
        endcase
      end
    end
  end

  // Read data valid the cycle after the read strobe only
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else if (rd_i)
    begin
      unique case (addr_i)
        `LCEM_ADDR_CTRL: rdata_o <= 32'(cfg_q);
        `LCEM_ADDR_BUSY: rdata_o <= 32'(busy_per_q);
        `LCEM_ADDR_SUPV: rdata_o <= 32'(supv_per_q);
        `LCEM_ADDR_STAT: rdata_o <= {12'h000, pr_q, 4'(ab_cnt_q),
                                     4'(ae_cnt_q), err_rate_high_o,
                                     supv_run_q, cong_q, 7'(se_cnt_q)};
        default:         rdata_o <= '0;
      endcase
    end
    else
      rdata_o <= '0;
  end

endmodule : lcem_top

// >>> verif/lcem_props.sv
`timescale 1ns/1ps
module lcem_props
  import lcem_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       rx_unit_i,
  input wire logic [5:0] rx_li_i,
  input wire logic [7:0] rx_octet_i,
  input wire lcem_lsu_s  rx_lsu_o,
  input wire logic       rx_lsu_valid_o,
  input wire logic       ack_delay_restart_o,
  input wire logic       congested_o,
  input wire logic       ack_enable_o,
  input wire logic       accept_msu_o,
  input wire logic       bsn_process_o,
  input wire logic       busy_lsu_req_o,
  input wire lcem_lsu_s  tx_status_octet_o,
  input wire logic [6:0] tx_bsn_o,
  input wire logic       tx_bib_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_lsu;
    rx_unit_i && (rx_li_i == 6'h01 || rx_li_i == 6'h02);
  endsequence
  sequence s_busy;
    s_lsu ##0 rx_octet_i[2:0] == 3'h5;
  endsequence

  busy_restart_a: assert property (s_busy |-> ##2 ack_delay_restart_o)
    else $error("busy unit did not restart ack delay timer");
  lsu_decode_a: assert property (s_lsu |=> rx_lsu_valid_o &&
    {5'h00, rx_lsu_o.code} == ($past(rx_octet_i) & 8'h07))
    else $error("status unit decode wrong");
  lsu_refuse_a: assert property (rx_unit_i && rx_li_i != 6'h01 &&
    rx_li_i != 6'h02 |=> !rx_lsu_valid_o)
    else $error("bad length decoded as status unit");
  cong_ack_a: assert property (congested_o |-> !ack_enable_o)
    else $error("acknowledgement while congested");
  cong_accept_a: assert property (!congested_o |-> accept_msu_o &&
    bsn_process_o)
    else $error("acceptance or backward processing off");
  busy_onset_a: assert property ($rose(congested_o) |=> busy_lsu_req_o)
    else $error("no busy unit at congestion onset");
  busy_code_a: assert property (busy_lsu_req_o |->
    tx_status_octet_o.code == LCEM_ST_B)
    else $error("busy unit without busy code");
  bsn_freeze_a: assert property (congested_o && $past(congested_o) &&
    $past(congested_o, 2) |-> $stable(tx_bsn_o) && $stable(tx_bib_o))
    else $error("backward fields moved while congested");
  busy_stop_a: assert property (!congested_o [*2] |-> !busy_lsu_req_o)
    else $error("busy unit after abatement");
endmodule : lcem_props

bind lcem_top lcem_props i_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .rx_unit_i(rx_unit_i), .rx_li_i(rx_li_i), .rx_octet_i(rx_octet_i),
  .rx_lsu_o(rx_lsu_o), .rx_lsu_valid_o(rx_lsu_valid_o),
  .ack_delay_restart_o(ack_delay_restart_o), .congested_o(congested_o),
  .ack_enable_o(ack_enable_o), .accept_msu_o(accept_msu_o),
  .bsn_process_o(bsn_process_o), .busy_lsu_req_o(busy_lsu_req_o),
  .tx_status_octet_o(tx_status_octet_o), .tx_bsn_o(tx_bsn_o),
  .tx_bib_o(tx_bib_o));

// >>> verif/lcem_far_end.sv
`timescale 1ns/1ps
module lcem_far_end
  import lcem_pkg::*;
(
  input  wire logic       mclk_i,
  output logic            unit_o,
  output logic      [5:0] li_o,
  output logic      [7:0] octet_o,
  output logic            pos_ack_o,
  output logic            neg_ack_o
);
  initial
  begin
    unit_o = 1'b0;
    li_o = 6'h00;
    octet_o = 8'h00;
    pos_ack_o = 1'b0;
    neg_ack_o = 1'b0;
  end

  // Spare bits random: the receiver must look at the code field only
  task send(input logic [5:0] li, input lcem_status_e c);
    @(posedge mclk_i);
    unit_o  <= 1'b1;
    li_o    <= li;
    octet_o <= {5'($urandom), c};
    @(posedge mclk_i);
    unit_o  <= 1'b0;
    // Lines invert once released so a stale value is never mistaken for data
    li_o    <= ~li_o;
    octet_o <= ~octet_o;
  endtask : send

  task ack(input logic pos);
    @(posedge mclk_i);
    pos_ack_o <= pos;
    neg_ack_o <= ~pos;
    @(posedge mclk_i);
    pos_ack_o <= 1'b0;
    neg_ack_o <= 1'b0;
  endtask : ack
endmodule : lcem_far_end

// >>> verif/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t %h %h", $time, (a), (b)); end end

module tb
  import lcem_pkg::*;
;
  localparam int TICK = 4;
  localparam int HOLD = 2;
  localparam int BUSYMS = 3;
  localparam int SUPVMS = 6;

  logic mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic cong_level_i = 1'b0, tx_unit_sent_i = 1'b0, tx_bib_i = 1'b0;
  logic [6:0] tx_bsn_i = 7'h00, tx_bsn_o, sb;
  logic tx_bib_o, ack_enable_o, accept_msu_o, bsn_process_o, sbib;
  logic congested_o, busy_lsu_req_o, rx_unit_i, rx_lsu_valid_o;
  lcem_status_e tx_status_i = LCEM_ST_O;
  lcem_lsu_s tx_status_octet_o, rx_lsu_o;
  logic [5:0] rx_li_i;
  logic [7:0] rx_octet_i;
  logic rx_pos_ack_i, rx_neg_ack_i, ack_delay_restart_o, link_fail_o;
  logic su_err_i = 1'b0, su_ok_i = 1'b0, octet_i = 1'b0;
  logic octet_mode_i = 1'b0, in_service_i = 1'b0, err_rate_high_o;
  logic prove_enter_i = 1'b0, prove_expire_i = 1'b0;
  logic prove_abort_o, prove_done_o, prove_oos_o;
  int checks, miscompares, cyc, n_f, n_a, n_d, n_o, n_b, b1, b2, f, a;
  int n_r;

  lcem_top #(.TICK_CYCLES(TICK), .CONG_HOLD(HOLD)) i_dut (.mclk_i, .rst_n_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cong_level_i,
    .tx_unit_sent_i, .tx_bsn_i, .tx_bib_i, .tx_bsn_o, .tx_bib_o,
    .ack_enable_o, .accept_msu_o, .bsn_process_o, .congested_o,
    .busy_lsu_req_o, .tx_status_i, .tx_status_octet_o, .rx_unit_i,
    .rx_li_i, .rx_octet_i, .rx_lsu_o, .rx_lsu_valid_o, .rx_pos_ack_i,
    .rx_neg_ack_i, .ack_delay_restart_o, .link_fail_o, .su_err_i,
    .su_ok_i, .octet_i, .octet_mode_i, .in_service_i, .err_rate_high_o,
    .prove_enter_i, .prove_expire_i, .prove_abort_o, .prove_done_o,
    .prove_oos_o);

  lcem_far_end i_far (.mclk_i(mclk_i), .unit_o(rx_unit_i), .li_o(rx_li_i),
    .octet_o(rx_octet_i), .pos_ack_o(rx_pos_ack_i),
    .neg_ack_o(rx_neg_ack_i));

  initial
  begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Errors are sent first, so saturation happens before any decrement
  function automatic logic [6:0] in_service_error_monitor(input int e, input int ok);
    int v;
    v = (e > 64 ? 64 : e) - (e + ok) / 256;
    return 7'(v < 0 ? 0 : v);
  endfunction : in_service_error_monitor

  task tally_and_finish;
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task cy(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cy

  task wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge mclk_i);
    addr_i  <= ad;
    wdata_i <= dt;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] ad);
    @(posedge mclk_i);
    addr_i <= ad;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  task ev(input int k, input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      case (k)
        0: su_err_i <= 1'b1;
        1: su_ok_i <= 1'b1;
        2: octet_i <= 1'b1;
        3: prove_expire_i <= 1'b1;
        4: prove_enter_i <= 1'b1;
        default: tx_unit_sent_i <= 1'b1;
      endcase
      @(posedge mclk_i);
      {su_err_i, su_ok_i, octet_i, prove_expire_i, prove_enter_i} <= 5'h0;
      tx_unit_sent_i <= 1'b0;
    end
  endtask : ev

  always @(posedge mclk_i)
  begin
    cyc++;
    n_f += (link_fail_o === 1'b1);
    n_r += (ack_delay_restart_o === 1'b1);
    n_a += (prove_abort_o === 1'b1);
    n_d += (prove_done_o === 1'b1);
    n_o += (prove_oos_o === 1'b1);
    if (busy_lsu_req_o === 1'b1)
    begin
      n_b++;
      b1 = b2;
      b2 = cyc;
    end
    if (cyc == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial
  begin
    void'($urandom(9106));
    cy(20);
    rst_n_i <= 1'b1;
    `CHK(ack_enable_o, 1'b1)
    `CHK(bsn_process_o & accept_msu_o, 1'b1)
    rd(8'h04);
    `CHK(d, 32'h64)
    rd(8'h08);
    `CHK(d, 32'hbb8)
    rd(8'h10);
    `CHK(d, 32'h0)
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c);
    `CHK(d, 32'h0)
    wr(8'h04, BUSYMS);
    wr(8'h08, SUPVMS);
    rd(8'h04);
    `CHK(d, 32'(BUSYMS))
    for (int c = 0; c < 6; c++)
    begin
      @(posedge mclk_i);
      tx_status_i <= lcem_status_e'(c);
      cy(2);
      `CHK(tx_status_octet_o, lcem_lsu_s'({5'h0, 3'(c)}))
    end
    for (int li = 0; li < 4; li++)
      for (int c = 0; c < 6; c++)
      begin
        i_far.send(6'(li), lcem_status_e'(c));
        #1;
        `CHK(rx_lsu_valid_o, 1'(li inside {1, 2}))
        if (li inside {1, 2})
          `CHK(rx_lsu_o.code, lcem_status_e'(c))
        i_far.ack(1'b1);
      end
    f = n_f;
    a = n_r;
    i_far.send(6'h01, LCEM_ST_B);
    cy(SUPVMS * TICK + 16);
    `CHK(n_f, f + 1)
    `CHK(n_r, a + 1)
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, {31'h0, i[1]});
      f = n_f;
      i_far.send(6'h02, LCEM_ST_B);
      cy(5);
      i_far.ack(!i[0]);
      cy(SUPVMS * TICK + 16);
      `CHK(n_f, f + int'(i == 3))
    end
    wr(8'h00, 32'h0);
    @(posedge mclk_i);
    cong_level_i <= 1'b1;
    cy(2);
    cong_level_i <= 1'b0;
    cy(20);
    `CHK(congested_o, 1'b0)
    sb = 7'($urandom);
    sbib = 1'($urandom);
    tx_bsn_i <= sb;
    tx_bib_i <= sbib;
    ev(5, 1);
    cong_level_i <= 1'b1;
    for (int k = 0; k < 60 && congested_o !== 1'b1; k++) @(posedge mclk_i);
    repeat (50)
    begin
      @(posedge mclk_i);
      tx_bsn_i <= 7'($urandom);
      tx_bib_i <= 1'($urandom);
      tx_unit_sent_i <= 1'($urandom);
    end
    `CHK({tx_bsn_o, tx_bib_o}, {sb, sbib})
    `CHK(ack_enable_o | accept_msu_o, 1'b0)
    `CHK(b2 - b1, BUSYMS * TICK)
    // Acceptance during congestion is a control option; acks stay withheld
    wr(8'h00, 32'h2);
    cy(1);
    `CHK({accept_msu_o, ack_enable_o}, 2'h2)
    wr(8'h00, 32'h0);
    tx_unit_sent_i <= 1'b0;
    cong_level_i <= 1'b0;
    for (int k = 0; k < 60 && congested_o !== 1'b0; k++) @(posedge mclk_i);
    cy(3);
    f = n_b;
    cy(30);
    `CHK(n_b, f)
    `CHK({ack_enable_o, tx_bsn_o}, {1'b1, tx_bsn_i})
    in_service_i <= 1'b1;
    ev(0, 63);
    cy(3);
    `CHK(err_rate_high_o, 1'b0)
    ev(0, 6);
    cy(3);
    `CHK(err_rate_high_o, 1'b1)
    rd(8'h0c);
    `CHK(d[6:0], in_service_error_monitor(69, 0))
    ev(1, 256);
    rd(8'h0c);
    `CHK({err_rate_high_o, d[6:0]}, {1'b0, in_service_error_monitor(69, 256)})
    @(posedge mclk_i);
    in_service_i <= 1'b0;
    cy(2);
    in_service_i <= 1'b1;
    octet_mode_i <= 1'b1;
    rd(8'h0c);
    `CHK(d[6:0], 7'h0)
    ev(2, 63);
    rd(8'h0c);
    `CHK(d[6:0], 7'(63 / 16))
    @(posedge mclk_i);
    octet_mode_i <= 1'b0;
    in_service_i <= 1'b0;
    ev(4, 1);
    a = n_a;
    f = n_o;
    ev(0, 3);
    rd(8'h0c);
    `CHK({n_a, d[13:10]}, {a, 4'h3})
    ev(0, 1);
    rd(8'h0c);
    `CHK({n_a, d[19:18]}, {a + 1, 2'h3})
    ev(1, 1);
    rd(8'h0c);
    `CHK(d[19:18], 2'h1)
    repeat (4)
    begin
      ev(0, 4);
      ev(3, 1);
    end
    rd(8'h0c);
    `CHK({n_o, d[19:18]}, {f + 1, 2'h0})
    wr(8'h00, 32'h4);
    ev(4, 1);
    a = n_a;
    ev(0, 1);
    cy(2);
    `CHK(n_a, a + 1)
    wr(8'h00, 32'h0);
    ev(4, 1);
    octet_mode_i <= 1'b1;
    ev(2, 32);
    rd(8'h0c);
    `CHK(d[13:10], 4'h2)
    @(posedge mclk_i);
    octet_mode_i <= 1'b0;
    ev(4, 1);
    f = n_d;
    ev(3, 1);
    cy(2);
    `CHK(n_d, f + 1)
    ev(4, 1);
    i_far.send(6'h01, LCEM_ST_O);
    ev(3, 1);
    cy(2);
    `CHK(n_d, f + 1)
    tally_and_finish();
  end
endmodule : tb
